// file: mdi_defines.svh
`ifndef MDI_DEFINES_SVH
`define MDI_DEFINES_SVH
// ==========================================================
// Data space map
`define MDI_GEN_LAST 16'h07ff
`define MDI_DRAM_FIRST 16'h1000
`define MDI_DRAM_LAST 16'h13ff
`define MDI_CFG_FIRST 16'h2000
`define MDI_CFG_LAST 16'h20ff
`define MDI_PRAM_FIRST 16'h3000
`define MDI_PRAM_LAST 16'h3fff
`define MDI_UNBACKED_DATA 8'hff
// ==========================================================
// Program memory
`define MDI_RESET_VECTOR 16'h0000
`define MDI_VECTOR_BASE 16'h0003
`define MDI_VECTOR_SHIFT 3
// ==========================================================
// Register offsets and reset values
`define MDI_OFF_STRETCH 12'h000
`define MDI_OFF_PAGE 12'h004
`define MDI_OFF_DATA_POINTER_A_A 12'h008
`define MDI_OFF_DATA_POINTER_A_B 12'h00c
`define MDI_OFF_PSEL 12'h010
`define MDI_OFF_STATUS 12'h014
`define MDI_STRETCH_RESET 3'h1
`define MDI_STRETCH_LSB 0
`define MDI_STRETCH_MSB 2
// ==========================================================
// Engine data RAM slots
`define MDI_SLOT_FILTER 2'h0
`define MDI_SLOT_MONITOR 2'h1
`define MDI_SLOT_CPU 2'h2
`define MDI_SLOT_LAST 2'h2
`endif

// file: mdi_pkg.sv
package mdi_pkg;
  typedef enum logic [2:0] {
    MDI_R_GEN, MDI_R_DRAM, MDI_R_CFG, MDI_R_PRAM, MDI_R_NONE
  } mdi_region_e;
  typedef struct packed {
    logic write;
    logic use_pointer;
    logic [7:0] low_byte;
    logic [7:0] wdata;
  } mdi_movx_s;
  typedef struct packed {
    logic [9:0] byte_addr;
    logic write;
    logic [7:0] wdata;
  } mdi_dram_req_s;
endpackage

// file: mdi_dram_port.sv
`timescale 1ns/100ps
`include "mdi_defines.svh"
module mdi_dram_port
  import mdi_pkg::*;
#(
  parameter int WORDS = 256
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Filter writer
  input wire logic filt_valid,
  input wire logic [2:0] filt_chan,
  input wire logic [31:0] filt_data,
  output logic filt_ready,
  // Sample monitor reader
  input wire logic mon_valid,
  input wire logic [7:0] mon_addr,
  output logic mon_ready,
  output logic [31:0] mon_data,
  // Processor side
  input wire logic cpu_req,
  input wire mdi_dram_req_s cpu_cmd,
  output logic cpu_done,
  output logic [7:0] cpu_rdata
);
  logic [31:0] mem [WORDS];
  logic [1:0] slot_reg;
  logic [1:0] slot_next;
  logic cpu_go;
  logic [7:0] cpu_word;
  logic [1:0] cpu_lane;

  // ==========================================================
  // Slot rotation
  assign slot_next = (slot_reg == `MDI_SLOT_LAST) ? `MDI_SLOT_FILTER : slot_reg + 2'h1;
  assign filt_ready = (slot_reg == `MDI_SLOT_FILTER);
  assign mon_ready = (slot_reg == `MDI_SLOT_MONITOR);
  assign cpu_go = cpu_req && !cpu_done && (slot_reg == `MDI_SLOT_CPU);
  assign cpu_word = cpu_cmd.byte_addr[9:2];
  assign cpu_lane = cpu_cmd.byte_addr[1:0];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      slot_reg <= `MDI_SLOT_FILTER;
      cpu_done <= 1'b0;
      cpu_rdata <= 8'h00;
      mon_data <= 32'h0;
    end else begin
      slot_reg <= slot_next;
      cpu_done <= cpu_go;
      if (mon_ready && mon_valid) begin
        mon_data <= mem[mon_addr];
      end
      if (cpu_go) begin
        cpu_rdata <= mem[cpu_word][8*cpu_lane +: 8];
      end
    end
  end

  // Each slot owns the port alone, so one write port suffices
  always_ff @(posedge mclk) begin
    if (filt_ready && filt_valid) begin
      mem[{5'h00, filt_chan}] <= filt_data;
    end else if (cpu_go && cpu_cmd.write) begin
      mem[cpu_word][8*cpu_lane +: 8] <= cpu_cmd.wdata;
    end
  end

  // ==========================================================
  // Checks
  property p_one_agent;
    @(posedge mclk) disable iff (!reset_n)
      !(cpu_go && (filt_ready || mon_ready));
  endproperty
  a_one_agent: assert property (p_one_agent) else $error("Two agents in one slot");

  property p_cpu_wait_bounded;
    @(posedge mclk) disable iff (!reset_n)
      $rose(cpu_req) |-> ##[1:4] cpu_done;
  endproperty
  a_cpu_wait_bounded: assert property (p_cpu_wait_bounded) else $error("Cpu slot never came");
endmodule // mdi_dram_port

// file: mdi_mem_if.sv
`timescale 1ns/100ps
`include "mdi_defines.svh"
// Notes on behaviour
// - Sixteen-bit data space; general RAM to 07ff, engine data RAM 1000-13ff.
// - Configuration RAM 2000-20ff, engine program RAM 3000-3fff.
// - Whole 64KB data space addressable; general and configuration RAM sit on the external bus, unbacked addresses read ff.
// - Only MOVX store/load requests make write/read cycles.
// - Indirect form takes high byte from page register, low from working register.
// - Low three bits of stretch control lengthen every MOVX access.
// - Stretch field resets to 001.
// - Read holds address valid and read strobe stretch+1 cycles.
// - Write address valid stretch+2; strobe 1 for stretch<2, else stretch.
// - Engine data RAM time-sliced: filter, monitor, processor slots.
// - Processor bytes pass holding registers; wait states until its slot.
// - Samples go to engine words 0-5 currents, 6 temperature, 7 neutral.
// - Byte writes into engine program RAM pack into 2-byte instructions.
// - Program memory 0000-ffff, for fetch and MOVC; fetch starts at 0000.
// - Interrupt vectors at 8-byte spacing from 0003.
// - Pointer select bit 0 picks data pointer a or b.
module mdi_mem_if
  import mdi_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core MOVX request
  input wire logic movx_req,
  input wire mdi_movx_s movx_cmd,
  output logic movx_ready,
  output logic movx_done,
  output logic [7:0] movx_rdata,
  // Program memory fetch
  input wire logic fetch_next,
  input wire logic fetch_jump,
  input wire logic [15:0] fetch_target,
  input wire logic irq_take,
  input wire logic [2:0] irq_num,
  input wire logic movc_req,
  input wire logic [15:0] movc_addr,
  output logic [15:0] prog_addr,
  // External data bus to general and configuration RAM
  output logic mem_addr_valid,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic gen_sel,
  output logic cfg_sel,
  input wire logic [7:0] gen_rdata,
  input wire logic [7:0] cfg_rdata,
  // Engine program RAM word port
  output logic prog_we,
  output logic [10:0] prog_waddr,
  output logic [15:0] prog_wdata,
  // Engine data RAM agents
  input wire logic filt_valid,
  input wire logic [2:0] filt_chan,
  input wire logic [31:0] filt_data,
  output logic filt_ready,
  input wire logic mon_valid,
  input wire logic [7:0] mon_addr,
  output logic mon_ready,
  output logic [31:0] mon_data
);
  typedef enum logic [0:0] {MDI_IDLE, MDI_ACCESS} mdi_state_e;

  // ==========================================================
  // Helpers
  function automatic mdi_region_e region_of(input logic [15:0] a);
    if (a <= `MDI_GEN_LAST) return MDI_R_GEN;
    if (a >= `MDI_DRAM_FIRST && a <= `MDI_DRAM_LAST) return MDI_R_DRAM;
    if (a >= `MDI_CFG_FIRST && a <= `MDI_CFG_LAST) return MDI_R_CFG;
    if (a >= `MDI_PRAM_FIRST && a <= `MDI_PRAM_LAST) return MDI_R_PRAM;
    return MDI_R_NONE;
  endfunction

  function automatic logic [15:0] vector_of(input logic [2:0] n);
    return `MDI_VECTOR_BASE + ({13'h0, n} << `MDI_VECTOR_SHIFT);
  endfunction

  // ==========================================================
  // Registers
  logic [7:0] stretch_ctl_reg;
  logic [7:0] page_high_byte_reg;
  logic [15:0] data_pointer_a_reg;
  logic [15:0] data_pointer_b_reg;
  logic [7:0] pointer_select_reg;
  mdi_state_e state_reg;
  logic [3:0] phase_reg;
  logic [3:0] total_reg;
  logic [3:0] wlen_reg;
  logic write_reg;
  mdi_region_e region_reg;
  logic [7:0] low_hold_reg;
  logic [15:0] pc_reg;
  logic movc_reg;

  logic apb_wr;
  logic [2:0] stretch;
  logic [15:0] sel_pointer;
  logic [15:0] req_addr;
  logic accept;
  logic last_phase;
  logic dram_req;
  logic dram_done;
  logic [7:0] dram_rdata;
  logic finish;
  logic [7:0] read_mux;
  logic hit;
  mdi_dram_req_s dram_cmd;

  // ==========================================================
  // APB decode, zero wait states
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign hit = (paddr == `MDI_OFF_STRETCH) || (paddr == `MDI_OFF_PAGE) ||
               (paddr == `MDI_OFF_DATA_POINTER_A_A) || (paddr == `MDI_OFF_DATA_POINTER_A_B) ||
               (paddr == `MDI_OFF_PSEL) || (paddr == `MDI_OFF_STATUS);
  assign pslverr = psel && penable && !hit;

  always_comb begin
    unique case (paddr)
      `MDI_OFF_STRETCH: prdata = {24'h0, stretch_ctl_reg};
      `MDI_OFF_PAGE: prdata = {24'h0, page_high_byte_reg};
      `MDI_OFF_DATA_POINTER_A_A: prdata = {16'h0, data_pointer_a_reg};
      `MDI_OFF_DATA_POINTER_A_B: prdata = {16'h0, data_pointer_b_reg};
      `MDI_OFF_PSEL: prdata = {24'h0, pointer_select_reg};
      `MDI_OFF_STATUS: prdata = {pc_reg, 12'h0, phase_reg[2:0], state_reg == MDI_ACCESS};
      default: prdata = 32'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stretch_ctl_reg <= {5'h00, `MDI_STRETCH_RESET};
      page_high_byte_reg <= 8'h00;
      data_pointer_a_reg <= 16'h0000;
      data_pointer_b_reg <= 16'h0000;
      pointer_select_reg <= 8'h00;
    end else if (apb_wr) begin
      if (paddr == `MDI_OFF_STRETCH) stretch_ctl_reg <= pwdata[7:0];
      if (paddr == `MDI_OFF_PAGE) page_high_byte_reg <= pwdata[7:0];
      if (paddr == `MDI_OFF_DATA_POINTER_A_A) data_pointer_a_reg <= pwdata[15:0];
      if (paddr == `MDI_OFF_DATA_POINTER_A_B) data_pointer_b_reg <= pwdata[15:0];
      if (paddr == `MDI_OFF_PSEL) pointer_select_reg <= pwdata[7:0];
    end
  end

  // ==========================================================
  // MOVX address forming and timing
  assign stretch = stretch_ctl_reg[`MDI_STRETCH_MSB:`MDI_STRETCH_LSB];
  assign sel_pointer = pointer_select_reg[0] ? data_pointer_b_reg : data_pointer_a_reg;
  assign req_addr = movx_cmd.use_pointer ? sel_pointer
                                         : {page_high_byte_reg, movx_cmd.low_byte};
  assign movx_ready = (state_reg == MDI_IDLE);
  assign accept = movx_req && movx_ready;
  assign last_phase = (phase_reg == total_reg - 4'h1);
  // Engine RAM extends the final phase until its slot answers
  assign dram_req = (state_reg == MDI_ACCESS) && last_phase && (region_reg == MDI_R_DRAM);
  assign finish = (state_reg == MDI_ACCESS) && last_phase &&
                  ((region_reg != MDI_R_DRAM) || dram_done);
  assign dram_cmd = '{byte_addr: mem_addr[9:0], write: write_reg, wdata: mem_wdata};

  assign mem_addr_valid = (state_reg == MDI_ACCESS);
  assign mem_rd = (state_reg == MDI_ACCESS) && !write_reg;
  assign mem_wr = (state_reg == MDI_ACCESS) && write_reg &&
                  (phase_reg != 4'h0) && (phase_reg <= wlen_reg);
  assign gen_sel = mem_addr_valid && (region_reg == MDI_R_GEN);
  assign cfg_sel = mem_addr_valid && (region_reg == MDI_R_CFG);

  always_comb begin
    unique case (region_reg)
      MDI_R_GEN: read_mux = gen_rdata;
      MDI_R_CFG: read_mux = cfg_rdata;
      MDI_R_DRAM: read_mux = dram_rdata;
      default: read_mux = `MDI_UNBACKED_DATA;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= MDI_IDLE;
      phase_reg <= 4'h0;
      total_reg <= 4'h1;
      wlen_reg <= 4'h1;
      write_reg <= 1'b0;
      region_reg <= MDI_R_NONE;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      movx_done <= 1'b0;
      movx_rdata <= 8'h00;
    end else begin
      movx_done <= finish;
      unique case (state_reg)
        MDI_IDLE: begin
          if (accept) begin
            state_reg <= MDI_ACCESS;
            phase_reg <= 4'h0;
            write_reg <= movx_cmd.write;
            total_reg <= movx_cmd.write ? {1'b0, stretch} + 4'h2 : {1'b0, stretch} + 4'h1;
            wlen_reg <= (stretch < 3'h2) ? 4'h1 : {1'b0, stretch};
            region_reg <= region_of(req_addr);
            mem_addr <= req_addr;
            mem_wdata <= movx_cmd.wdata;
          end
        end
        MDI_ACCESS: begin
          if (finish) begin
            state_reg <= MDI_IDLE;
            if (!write_reg) movx_rdata <= read_mux;
          end else if (!last_phase) begin
            phase_reg <= phase_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Engine program RAM packing, low byte first
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      low_hold_reg <= 8'h00;
      prog_we <= 1'b0;
      prog_waddr <= 11'h000;
      prog_wdata <= 16'h0000;
    end else begin
      prog_we <= 1'b0;
      if (finish && write_reg && region_reg == MDI_R_PRAM) begin
        if (!mem_addr[0]) begin
          low_hold_reg <= mem_wdata;
        end else begin
          prog_we <= 1'b1;
          prog_waddr <= mem_addr[11:1];
          prog_wdata <= {mem_wdata, low_hold_reg};
        end
      end
    end
  end

  // ==========================================================
  // Program memory fetch and MOVC table reads
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pc_reg <= `MDI_RESET_VECTOR;
      movc_reg <= 1'b0;
      prog_addr <= `MDI_RESET_VECTOR;
    end else begin
      movc_reg <= movc_req;
      if (irq_take) pc_reg <= vector_of(irq_num);
      else if (fetch_jump) pc_reg <= fetch_target;
      else if (fetch_next) pc_reg <= pc_reg + 16'h0001;
      prog_addr <= movc_req ? movc_addr : (irq_take ? vector_of(irq_num) : pc_reg);
    end
  end

  mdi_dram_port #(
    .WORDS(256)
  ) u_dram (
    .mclk(mclk),
    .reset_n(reset_n),
    .filt_valid(filt_valid),
    .filt_chan(filt_chan),
    .filt_data(filt_data),
    .filt_ready(filt_ready),
    .mon_valid(mon_valid),
    .mon_addr(mon_addr),
    .mon_ready(mon_ready),
    .mon_data(mon_data),
    .cpu_req(dram_req),
    .cpu_cmd(dram_cmd),
    .cpu_done(dram_done),
    .cpu_rdata(dram_rdata)
  );

  // ==========================================================
  // Checks
  logic [3:0] rd_len;
  logic [3:0] wr_len;
  logic [3:0] av_len;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_len <= 4'h0;
      wr_len <= 4'h0;
      av_len <= 4'h0;
    end else begin
      rd_len <= mem_rd ? rd_len + 4'h1 : 4'h0;
      wr_len <= mem_wr ? wr_len + 4'h1 : 4'h0;
      av_len <= mem_addr_valid ? av_len + 4'h1 : 4'h0;
    end
  end

  property p_read_width;
    @(posedge mclk) disable iff (!reset_n)
      ($fell(mem_rd) && region_reg != MDI_R_DRAM) |-> rd_len == {1'b0, stretch} + 4'h1;
  endproperty
  a_read_width: assert property (p_read_width) else $error("Read strobe width wrong");

  property p_write_addr_width;
    @(posedge mclk) disable iff (!reset_n)
      ($fell(mem_addr_valid) && write_reg && region_reg != MDI_R_DRAM)
        |-> av_len == {1'b0, stretch} + 4'h2;
  endproperty
  a_write_addr_width: assert property (p_write_addr_width) else $error("Write address width wrong");

  property p_write_strobe;
    @(posedge mclk) disable iff (!reset_n)
      $fell(mem_wr) |-> wr_len == ((stretch < 3'h2) ? 4'h1 : {1'b0, stretch});
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("Write strobe width wrong");

  property p_stretch_reset;
    @(posedge mclk) $rose(reset_n) |-> stretch_ctl_reg[2:0] == `MDI_STRETCH_RESET;
  endproperty
  a_stretch_reset: assert property (p_stretch_reset) else $error("Stretch not 1 after reset");

  property p_paged_addr;
    @(posedge mclk) disable iff (!reset_n)
      (accept && !movx_cmd.use_pointer) |=> mem_addr == {$past(page_high_byte_reg), $past(movx_cmd.low_byte)};
  endproperty
  a_paged_addr: assert property (p_paged_addr) else $error("Paged address wrong");

  property p_pointer_pick;
    @(posedge mclk) disable iff (!reset_n)
      (accept && movx_cmd.use_pointer && pointer_select_reg[0]) |=> mem_addr == $past(data_pointer_b_reg);
  endproperty
  a_pointer_pick: assert property (p_pointer_pick) else $error("Wrong data pointer");

  property p_unbacked_read;
    @(posedge mclk) disable iff (!reset_n)
      (finish && !write_reg && region_reg == MDI_R_NONE) |=> movx_rdata == `MDI_UNBACKED_DATA;
  endproperty
  a_unbacked_read: assert property (p_unbacked_read) else $error("Unbacked read value wrong");

  property p_vector;
    @(posedge mclk) disable iff (!reset_n)
      (irq_take && !fetch_jump) |=> pc_reg == 16'h0003 + 16'h0008 * $past(irq_num);
  endproperty
  a_vector: assert property (p_vector) else $error("Vector address wrong");

  property p_fetch_start;
    @(posedge mclk) $rose(reset_n) |-> prog_addr == `MDI_RESET_VECTOR && pc_reg == `MDI_RESET_VECTOR;
  endproperty
  a_fetch_start: assert property (p_fetch_start) else $error("Fetch not from 0000");
endmodule // mdi_mem_if

// file: mdi_mem_model.sv
`timescale 1ns/100ps
// ==========================================================
// General and configuration RAM standing behind the data bus
module mdi_mem_model (
  // Clock
  input wire logic mclk,
  // Data bus from the interface
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic gen_sel,
  input wire logic cfg_sel,
  // Read data back
  output logic [7:0] gen_rdata,
  output logic [7:0] cfg_rdata
);
  logic [7:0] gen_mem [0:2047];
  logic [7:0] cfg_mem [0:255];
  logic [7:0] last_g = 8'h00;
  logic [7:0] last_c = 8'h00;
  always @(posedge mclk) begin
    if (mem_wr && gen_sel) gen_mem[mem_addr[10:0]] <= mem_wdata;
    if (mem_wr && cfg_sel) cfg_mem[mem_addr[7:0]] <= mem_wdata;
    if (mem_rd && gen_sel) last_g <= gen_mem[mem_addr[10:0]];
    if (mem_rd && cfg_sel) last_c <= cfg_mem[mem_addr[7:0]];
  end
  // Released bus shows inverted data, so stale values cannot pass
  assign gen_rdata = (mem_rd && gen_sel) ? gen_mem[mem_addr[10:0]] : ~last_g;
  assign cfg_rdata = (mem_rd && cfg_sel) ? cfg_mem[mem_addr[7:0]] : ~last_c;
endmodule // mdi_mem_model

// file: mdi_mem_if_tb.sv
`timescale 1ns/100ps
module mdi_mem_if_tb;
  import mdi_pkg::*;
  logic mclk = 1'b0, reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic movx_req = 1'b0, movx_ready, movx_done;
  mdi_movx_s movx_cmd = '0;
  logic [7:0] movx_rdata, gen_rdata, cfg_rdata, mem_wdata, rd8;
  logic fetch_next = 1'b0, fetch_jump = 1'b0, irq_take = 1'b0, movc_req = 1'b0;
  logic [15:0] fetch_target = 16'h0, movc_addr = 16'h0, prog_addr, mem_addr, last_addr;
  logic [2:0] irq_num = 3'h0, filt_chan = 3'h0;
  logic mem_addr_valid, mem_rd, mem_wr, gen_sel, cfg_sel, prog_we, seen_g, seen_c, err;
  logic [10:0] prog_waddr, pw_a;
  logic [15:0] prog_wdata, pw_d;
  logic filt_valid = 1'b0, filt_ready, mon_valid = 1'b0, mon_ready;
  logic [31:0] filt_data = 32'h0, mon_data;
  logic [7:0] mon_addr = 8'h00;
  int mismatches = 0, num_checks = 0, n_av, n_rd, n_wr, n_pw;

  always #5 mclk = ~mclk;

  mdi_mem_if DUT (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .movx_req(movx_req), .movx_cmd(movx_cmd), .movx_ready(movx_ready),
    .movx_done(movx_done), .movx_rdata(movx_rdata), .fetch_next(fetch_next),
    .fetch_jump(fetch_jump), .fetch_target(fetch_target), .irq_take(irq_take),
    .irq_num(irq_num), .movc_req(movc_req), .movc_addr(movc_addr), .prog_addr(prog_addr),
    .mem_addr_valid(mem_addr_valid), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .gen_sel(gen_sel), .cfg_sel(cfg_sel), .gen_rdata(gen_rdata),
    .cfg_rdata(cfg_rdata), .prog_we(prog_we), .prog_waddr(prog_waddr),
    .prog_wdata(prog_wdata), .filt_valid(filt_valid), .filt_chan(filt_chan),
    .filt_data(filt_data), .filt_ready(filt_ready), .mon_valid(mon_valid),
    .mon_addr(mon_addr), .mon_ready(mon_ready), .mon_data(mon_data));

  mdi_mem_model u_mem (.mclk(mclk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .gen_sel(gen_sel), .cfg_sel(cfg_sel), .gen_rdata(gen_rdata),
    .cfg_rdata(cfg_rdata));

  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // Sampled at the rising edge itself; idle edge after so calls never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk); rv = prdata; err = pslverr;
    end while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic movx(input logic w, input logic p, input logic [7:0] lo, input logic [7:0] wd);
    logic r;
    int n;
    movx_req <= 1'b1; movx_cmd <= '{write: w, use_pointer: p, low_byte: lo, wdata: wd};
    do begin @(negedge mclk); r = movx_ready; @(posedge mclk); end while (r !== 1'b1);
    movx_req <= 1'b0;
    n = 0; n_av = 0; n_rd = 0; n_wr = 0; n_pw = 0; seen_g = 0; seen_c = 0;
    do begin
      @(negedge mclk);
      n++;
      if (mem_addr_valid === 1'b1) begin n_av++; last_addr = mem_addr; end
      if (mem_rd === 1'b1) n_rd++;
      if (mem_wr === 1'b1) n_wr++;
      if (gen_sel === 1'b1) seen_g = 1;
      if (cfg_sel === 1'b1) seen_c = 1;
      if (prog_we === 1'b1) begin n_pw++; pw_a = prog_waddr; pw_d = prog_wdata; end
      r = movx_done; rd8 = movx_rdata;
      @(posedge mclk);
    end while (r !== 1'b1 && n < 40);
    chk(n < 40, 1, "movx never finished");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_regs;
    chk(prog_addr, 16'h0000, "fetch start");
    apb(1'b0, 12'h000, 32'h0); chk(rv, 32'h1, "stretch reset");
    apb(1'b0, 12'h018, 32'h0); chk({err, rv}, 33'h1_0000_0000, "unmapped read");
    apb(1'b1, 12'h018, 32'h5); chk(err, 1'b1, "unmapped write error");
    apb(1'b0, 12'h014, 32'h0); chk(rv, 32'h0, "status after reset");
  endtask

  task automatic t_stretch;
    apb(1'b1, 12'h008, 32'h0010);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, 12'h000, s);
      movx(1'b1, 1'b1, 8'h00, 8'(s + 8'h40));
      chk(n_av, s + 2, "write addr width");
      chk(n_wr, (s < 2) ? 1 : s, "write strobe width");
      movx(1'b0, 1'b1, 8'h00, 8'h00);
      chk(n_av, s + 1, "read addr width");
      chk(n_rd, s + 1, "read strobe width");
      chk(rd8, 8'(s + 8'h40), "read back");
    end
  endtask

  task automatic t_pointers;
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h00c, 32'h07ff);
    apb(1'b1, 12'h010, 32'h1);
    movx(1'b1, 1'b1, 8'h00, 8'h5a);
    chk({last_addr, seen_g}, {16'h07ff, 1'b1}, "second pointer");
    apb(1'b1, 12'h010, 32'h0);
    movx(1'b0, 1'b1, 8'h00, 8'h00);
    chk(last_addr, 16'h0010, "first pointer");
    apb(1'b1, 12'h004, 32'h20);
    movx(1'b1, 1'b0, 8'h05, 8'h77);
    chk({last_addr, seen_c}, {16'h2005, 1'b1}, "paged address");
    movx(1'b0, 1'b0, 8'h05, 8'h00);
    chk(rd8, 8'h77, "config read");
  endtask

  task automatic t_unbacked;
    apb(1'b1, 12'h004, 32'h08);
    movx(1'b1, 1'b0, 8'h00, 8'h11);
    chk({seen_g, seen_c, n_av}, {2'b00, 32'd3}, "unbacked write");
    movx(1'b0, 1'b0, 8'h00, 8'h00);
    chk({rd8, n_rd}, {8'hff, 32'd2}, "unbacked read");
    apb(1'b1, 12'h008, 32'hffff);
    movx(1'b0, 1'b1, 8'h00, 8'h00);
    chk({last_addr, rd8}, {16'hffff, 8'hff}, "top of space");
  endtask

  task automatic t_prog_pack;
    apb(1'b1, 12'h008, 32'h3004);
    movx(1'b1, 1'b1, 8'h00, 8'h34);
    chk(n_pw, 0, "even byte held");
    apb(1'b1, 12'h008, 32'h3005);
    movx(1'b1, 1'b1, 8'h00, 8'h12);
    chk({n_pw, pw_a, pw_d}, {32'd1, 11'h002, 16'h1234}, "packed word");
  endtask

  task automatic t_engine_ram;
    logic r;
    filt_valid <= 1'b1; filt_chan <= 3'h7; filt_data <= 32'ha1b2c3d4;
    do begin @(negedge mclk); r = filt_ready; @(posedge mclk); end while (r !== 1'b1);
    filt_valid <= 1'b0;
    mon_valid <= 1'b1; mon_addr <= 8'h07;
    do begin @(negedge mclk); r = mon_ready; @(posedge mclk); end while (r !== 1'b1);
    mon_valid <= 1'b0;
    @(negedge mclk);
    chk(mon_data, 32'ha1b2c3d4, "neutral sample word");
    @(posedge mclk);
    apb(1'b1, 12'h008, 32'h101c);
    movx(1'b0, 1'b1, 8'h00, 8'h00);
    chk(rd8, 8'hd4, "engine byte via holding");
  endtask

  task automatic t_fetch;
    irq_take <= 1'b1; irq_num <= 3'h2;
    @(posedge mclk);
    irq_take <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(prog_addr, 16'h0013, "vector address");
    fetch_jump <= 1'b1; fetch_target <= 16'h1230;
    @(posedge mclk);
    fetch_jump <= 1'b0; fetch_next <= 1'b1;
    @(posedge mclk);
    fetch_next <= 1'b0; movc_req <= 1'b1; movc_addr <= 16'hbeef;
    @(posedge mclk);
    movc_req <= 1'b0;
    @(posedge mclk);
    chk(prog_addr, 16'hbeef, "table read address");
    @(posedge mclk);
    chk(prog_addr, 16'h1231, "jump then next");
  endtask

  // ==========================================================
  // Verdict
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset_regs();
    t_stretch();
    t_pointers();
    t_unbacked();
    t_prog_pack();
    t_engine_ram();
    t_fetch();
    summarize();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule // mdi_mem_if_tb
